// ===== rtl/bva_pkg.sv
package bva_pkg;
    // ----------------------------------------------------------------
    // threshold field layout
    // ----------------------------------------------------------------
    localparam int unsigned THR_W = 14;       // threshold / code width
    localparam int unsigned THR_LSB = 2;      // field low bit in register
    localparam int unsigned THR_MSB = 15;     // field high bit in register
    localparam int unsigned ADR_W = 8;        // wishbone byte address width
    localparam int unsigned IDX_W = 6;        // register index width

    // ----------------------------------------------------------------
    // register indices, byte address is four times the index
    // ----------------------------------------------------------------
    localparam logic [5:0] IDX_OV_CLR = 6'h24;   // bipolar_overvolt_clear_level
    localparam logic [5:0] IDX_OV_SET = 6'h25;   // bipolar_overvolt_set_level
    localparam logic [5:0] IDX_UV_CLR = 6'h26;   // bipolar_undervolt_clear_level
    localparam logic [5:0] IDX_UV_SET = 6'h27;   // bipolar_undervolt_set_level
    localparam logic [5:0] IDX_STATUS = 6'h30;   // sticky event status, w1c
    localparam logic [5:0] IDX_MASK = 6'h31;     // interrupt mask
    localparam logic [5:0] IDX_ALERT = 6'h32;    // any-cell alert levels, ro

    // ----------------------------------------------------------------
    // reset values and disable codes
    // ----------------------------------------------------------------
    localparam logic [13:0] RST_OV_CLR = 14'h3fff;
    localparam logic [13:0] RST_OV_SET = 14'h3fff;
    localparam logic [13:0] RST_UV_CLR = 14'h0000;
    localparam logic [13:0] RST_UV_SET = 14'h0000;
    localparam logic [13:0] OV_OFF_CODE = 14'h3fff;  // overvoltage check off
    localparam logic [13:0] UV_OFF_CODE = 14'h0000;  // undervoltage check off

    // ----------------------------------------------------------------
    // event bits of status and mask
    // ----------------------------------------------------------------
    localparam int unsigned EVT_OV = 0;    // some overvoltage alert rose
    localparam int unsigned EVT_UV = 1;    // some undervoltage alert rose
    localparam int unsigned EVT_W = 2;
    localparam logic [1:0] RST_EVT = 2'h0;
endpackage : bva_pkg

// ===== rtl/bva_top.sv
`timescale 1ns/1ps
module bva_top #(
    parameter int unsigned NUM_CELLS = 14,
    parameter int unsigned CELL_W = 4
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [bva_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // bipolar measurement results
    input wire logic meas_valid_i,
    input wire logic [CELL_W-1:0] meas_cell_i,
    input wire logic [bva_pkg::THR_W-1:0] meas_code_i,
    // alerts and interrupt
    output logic [NUM_CELLS-1:0] cell_overvoltage_alert_o,
    output logic [NUM_CELLS-1:0] cell_undervoltage_alert_o,
    output logic irq_o
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // merge byte lanes of a write into a 14-bit field at bits 15:2
    function automatic logic [13:0] merge_thr(
        input logic [13:0] old_v,
        input logic [31:0] dat,
        input logic [3:0] sel
    );
        logic [13:0] res;
        res = old_v;
        if (sel[1])
        begin
            res[13:6] = dat[15:8];
        end
        if (sel[0])
        begin
            res[5:0] = dat[7:2]; // bits 1:0 dropped
        end
        return res;
    endfunction : merge_thr

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [13:0] ov_clr;        // bipolar_overvolt_clear_level
    logic [13:0] ov_set;        // bipolar_overvolt_set_level
    logic [13:0] uv_clr;        // bipolar_undervolt_clear_level
    logic [13:0] uv_set;        // bipolar_undervolt_set_level
    logic [1:0] evt_status;     // sticky events
    logic [1:0] evt_mask;       // interrupt enables
    logic [NUM_CELLS-1:0] next_ov;
    logic [NUM_CELLS-1:0] next_uv;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire [5:0] idx = wb_adr_i[7:2];                      // word index
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;        // new access
    wire wr = req && wb_we_i;                            // write strobe
    wire wr_ov_clr = wr && (idx == bva_pkg::IDX_OV_CLR);
    wire wr_ov_set = wr && (idx == bva_pkg::IDX_OV_SET);
    wire wr_uv_clr = wr && (idx == bva_pkg::IDX_UV_CLR);
    wire wr_uv_set = wr && (idx == bva_pkg::IDX_UV_SET);
    wire wr_status = wr && (idx == bva_pkg::IDX_STATUS) && wb_sel_i[0];
    wire wr_mask = wr && (idx == bva_pkg::IDX_MASK) && wb_sel_i[0];
    wire is_thr = (idx >= bva_pkg::IDX_OV_CLR) && (idx <= bva_pkg::IDX_UV_SET);

    // read selection; unmapped words read zero
    wire [31:0] rd_word =
        (idx == bva_pkg::IDX_OV_CLR) ? {16'h0000, ov_clr, 2'b00} :
        (idx == bva_pkg::IDX_OV_SET) ? {16'h0000, ov_set, 2'b00} :
        (idx == bva_pkg::IDX_UV_CLR) ? {16'h0000, uv_clr, 2'b00} :
        (idx == bva_pkg::IDX_UV_SET) ? {16'h0000, uv_set, 2'b00} :
        (idx == bva_pkg::IDX_STATUS) ? {30'h0000_0000, evt_status} :
        (idx == bva_pkg::IDX_MASK) ? {30'h0000_0000, evt_mask} :
        (idx == bva_pkg::IDX_ALERT) ?
            {30'h0000_0000, |cell_undervoltage_alert_o, |cell_overvoltage_alert_o} :
        32'h0000_0000;

    // ----------------------------------------------------------------
    // bus response
    // ----------------------------------------------------------------
    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= req;
            wb_dat_o <= req ? rd_word : wb_dat_o;
        end
    end

    // ----------------------------------------------------------------
    // threshold registers
    // ----------------------------------------------------------------
    // reset values then byte-lane writes
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            ov_clr <= bva_pkg::RST_OV_CLR;
            ov_set <= bva_pkg::RST_OV_SET;
            uv_clr <= bva_pkg::RST_UV_CLR;
            uv_set <= bva_pkg::RST_UV_SET;
        end
        else
        begin
            ov_clr <= wr_ov_clr ? merge_thr(ov_clr, wb_dat_i, wb_sel_i) : ov_clr;
            ov_set <= wr_ov_set ? merge_thr(ov_set, wb_dat_i, wb_sel_i) : ov_set;
            uv_clr <= wr_uv_clr ? merge_thr(uv_clr, wb_dat_i, wb_sel_i) : uv_clr;
            uv_set <= wr_uv_set ? merge_thr(uv_set, wb_dat_i, wb_sel_i) : uv_set;
        end
    end

    // ----------------------------------------------------------------
    // comparison against measurement
    // ----------------------------------------------------------------
    wire signed [13:0] meas_s = $signed(meas_code_i);
    wire ov_off = (ov_set == bva_pkg::OV_OFF_CODE);
    wire uv_off = (uv_set == bva_pkg::UV_OFF_CODE);
    wire ov_raise = !ov_off && (meas_s > $signed(ov_set));
    wire ov_drop = (meas_s <= $signed(ov_clr));
    wire uv_raise = !uv_off && (meas_s < $signed(uv_set));
    wire uv_drop = (meas_s >= $signed(uv_clr));

    // per-cell alert update; set wins, in-band holds
    genvar k;
    generate
        for (k = 0; k < NUM_CELLS; k = k + 1)
        begin : g_cell
            wire hit = meas_valid_i && (meas_cell_i == CELL_W'(k));
            assign next_ov[k] = !hit ? cell_overvoltage_alert_o[k] :
                                ov_raise ? 1'b1 :
                                ov_drop ? 1'b0 :
                                cell_overvoltage_alert_o[k];
            assign next_uv[k] = !hit ? cell_undervoltage_alert_o[k] :
                                uv_raise ? 1'b1 :
                                uv_drop ? 1'b0 :
                                cell_undervoltage_alert_o[k];
        end
    endgenerate

    // ----------------------------------------------------------------
    // alert, status, mask and interrupt
    // ----------------------------------------------------------------
    wire [1:0] evt_new = {|(next_uv & ~cell_undervoltage_alert_o),
                          |(next_ov & ~cell_overvoltage_alert_o)};
    wire [1:0] w1c = wr_status ? wb_dat_i[1:0] : 2'b00;
    wire [1:0] next_status = (evt_status & ~w1c) | evt_new;   // set beats clear

    // alerts, sticky status, mask
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            cell_overvoltage_alert_o <= '0;
            cell_undervoltage_alert_o <= '0;
            evt_status <= bva_pkg::RST_EVT;
            evt_mask <= bva_pkg::RST_EVT;
        end
        else
        begin
            cell_overvoltage_alert_o <= next_ov;
            cell_undervoltage_alert_o <= next_uv;
            evt_status <= next_status;
            evt_mask <= wr_mask ? wb_dat_i[1:0] : evt_mask;
        end
    end

    // level interrupt from unmasked sticky bits
    assign irq_o = |(evt_status & evt_mask);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [CELL_W-1:0] chk_cell;   // cell input of the previous cycle, valid or not
    always_ff @(posedge clk_i)
    begin
        chk_cell <= meas_cell_i;
    end
    wire cur_ov = cell_overvoltage_alert_o[meas_cell_i];
    wire cur_uv = cell_undervoltage_alert_o[meas_cell_i];

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_ov_raise_alert: assert property (
        meas_valid_i && (meas_cell_i < NUM_CELLS) && ov_set != 14'h3fff
        && $signed(meas_code_i) > $signed(ov_set) |=> cell_overvoltage_alert_o[chk_cell])
        else $error("overvoltage alert not raised");
    a_ov_disabled: assert property (
        meas_valid_i && (meas_cell_i < NUM_CELLS) && ov_set == 14'h3fff && !cur_ov
        |=> !cell_overvoltage_alert_o[chk_cell])
        else $error("overvoltage raised while disabled");
    a_ov_set_reset: assert property (
        $rose(rst_n_i) |-> ov_set == 14'h3fff && ov_clr == 14'h3fff)
        else $error("overvoltage levels wrong after reset");
    a_uv_clear_alert: assert property (
        meas_valid_i && (meas_cell_i < NUM_CELLS) && !uv_raise
        && $signed(meas_code_i) >= $signed(uv_clr) |=> !cell_undervoltage_alert_o[chk_cell])
        else $error("undervoltage alert not cleared");
    a_signed_compare: assert property (
        meas_valid_i && (meas_cell_i < NUM_CELLS) && meas_code_i[13] && !ov_set[13] && !cur_ov
        |=> !cell_overvoltage_alert_o[chk_cell])
        else $error("negative code treated as large");
    a_uv_clr_reset: assert property (
        $rose(rst_n_i) |-> uv_clr == 14'h0000)
        else $error("undervoltage clear level wrong after reset");
    a_uv_set_reset: assert property (
        $rose(rst_n_i) |-> uv_set == 14'h0000 ##1 (uv_set == $past(uv_set) || $past(wr_uv_set)))
        else $error("undervoltage set level wrong");
    a_uv_raise_alert: assert property (
        meas_valid_i && (meas_cell_i < NUM_CELLS) && uv_set != 14'h0000
        && $signed(meas_code_i) < $signed(uv_set) |=> cell_undervoltage_alert_o[chk_cell])
        else $error("undervoltage alert not raised");
    a_ov_clear_alert: assert property (
        meas_valid_i && (meas_cell_i < NUM_CELLS) && !ov_raise
        && $signed(meas_code_i) <= $signed(ov_clr) |=> !cell_overvoltage_alert_o[chk_cell])
        else $error("overvoltage alert not cleared");
    a_band_hold: assert property (
        meas_valid_i && (meas_cell_i < NUM_CELLS) && !ov_raise && !ov_drop
        |=> cell_overvoltage_alert_o[chk_cell] == $past(cur_ov))
        else $error("overvoltage alert moved inside band");
    a_low_bits_zero: assert property (
        req && !wb_we_i && is_thr |=> wb_ack_o && wb_dat_o[1:0] == 2'b00 && wb_dat_o[31:16] == 16'h0000)
        else $error("threshold read shows unused bits");

    // ----------------------------------------------------------------
    // bus handshake checks
    // ----------------------------------------------------------------
    // every taken request is answered on the next edge
    a_ack_follows_req: assert property (
        req |=> wb_ack_o)
        else $error("request not acknowledged");

    // ack is a one-cycle pulse, so a held strobe is taken every other cycle
    a_ack_single_pulse: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    // ----------------------------------------------------------------
    // register write checks
    // ----------------------------------------------------------------
    // a write on both lanes lands whole in the overvoltage set level
    a_ov_set_write: assert property (
        wr_ov_set && (wb_sel_i[1:0] == 2'b11)
        |=> ov_set == $past(wb_dat_i[15:2]))
        else $error("overvoltage set level not written");

    // a write on both lanes lands whole in the undervoltage clear level
    a_uv_clr_write: assert property (
        wr_uv_clr && (wb_sel_i[1:0] == 2'b11)
        |=> uv_clr == $past(wb_dat_i[15:2]))
        else $error("undervoltage clear level not written");

    // a write on both lanes lands whole in the undervoltage set level
    a_uv_set_write: assert property (
        wr_uv_set && (wb_sel_i[1:0] == 2'b11)
        |=> uv_set == $past(wb_dat_i[15:2]))
        else $error("undervoltage set level not written");

    // ----------------------------------------------------------------
    // undervoltage and idle alert checks
    // ----------------------------------------------------------------
    // a zero set level never raises a fresh undervoltage alert
    a_uv_disabled: assert property (
        meas_valid_i && (meas_cell_i < NUM_CELLS) && uv_set == 14'h0000 && !cur_uv
        |=> !cell_undervoltage_alert_o[chk_cell])
        else $error("undervoltage raised while disabled");

    // inside the undervoltage band the alert keeps its level
    a_uv_band_hold: assert property (
        meas_valid_i && (meas_cell_i < NUM_CELLS) && !uv_raise && !uv_drop
        |=> cell_undervoltage_alert_o[chk_cell] == $past(cur_uv))
        else $error("undervoltage alert moved inside band");

    // without a measurement no alert moves at all
    a_alerts_idle: assert property (
        !meas_valid_i
        |=> $stable(cell_overvoltage_alert_o) && $stable(cell_undervoltage_alert_o))
        else $error("alert moved without a measurement");

    // ----------------------------------------------------------------
    // event and mask checks
    // ----------------------------------------------------------------
    // a new event always lands, even against a clear in the same cycle
    a_status_set_wins: assert property (
        (|evt_new)
        |=> (evt_status & $past(evt_new)) == $past(evt_new))
        else $error("event lost in status");

    // writing one clears a status bit when no event races it
    a_status_w1c: assert property (
        wr_status && (evt_new == 2'b00)
        |=> (evt_status & $past(wb_dat_i[1:0])) == 2'b00)
        else $error("status bit not cleared by write");

    // mask takes the written low bits
    a_mask_write: assert property (
        wr_mask
        |=> evt_mask == $past(wb_dat_i[1:0]))
        else $error("mask not written");
endmodule : bva_top

// ===== test/bva_top_tb.sv
`timescale 1ns/1ps
module bva_top_tb;
    // ----------------------------------------------------------------
    // stimulus, model state and counters
    // ----------------------------------------------------------------
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [3:0] sel_v = 4'hf;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
    logic wb_ack_o, meas_valid_i = 1'b0, irq_o;
    logic [3:0] meas_cell_i = 4'h0;
    logic [13:0] meas_code_i = 14'h0000, cell_overvoltage_alert_o, cell_undervoltage_alert_o;
    logic [13:0] ov_set = 14'h3fff, ov_clr = 14'h3fff, uv_set = 14'h0000, uv_clr = 14'h0000;
    logic [13:0] ov_m = 14'h0000, uv_m = 14'h0000, ta, tb;
    logic [1:0] st_m = 2'h0, mask_m = 2'h0;
    int mismatches = 0;
    int cmp_count = 0;

    // 25 MHz clock
    always #20 clk_i = ~clk_i;

    bva_top #(.NUM_CELLS(14), .CELL_W(4)) u_bva_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .meas_valid_i(meas_valid_i), .meas_cell_i(meas_cell_i),
        .meas_code_i(meas_code_i), .cell_overvoltage_alert_o(cell_overvoltage_alert_o),
        .cell_undervoltage_alert_o(cell_undervoltage_alert_o), .irq_o(irq_o));

    // ----------------------------------------------------------------
    // checking and closing
    // ----------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop

    // expected alert levels, signed compare, set wins over clear
    function automatic logic ov_next(input logic o, input logic [13:0] c);
        if (ov_set !== 14'h3fff && $signed(c) > $signed(ov_set))
            return 1'b1;
        if ($signed(c) <= $signed(ov_clr))
            return 1'b0;
        return o;
    endfunction : ov_next

    function automatic logic uv_next(input logic u, input logic [13:0] c);
        if (uv_set !== 14'h0000 && $signed(c) < $signed(uv_set))
            return 1'b1;
        if ($signed(c) >= $signed(uv_clr))
            return 1'b0;
        return u;
    endfunction : uv_next

    // one classic cycle, held until ack, bounded wait
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel_v;
        wb_dat_i <= dat;
        for (n = 0; n < 16 && wb_ack_o !== 1'b1; n++)
            @(posedge clk_i);
        if (wb_ack_o !== 1'b1)
        begin
            mismatches++;
            report_and_stop();
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb

    // threshold write with junk in bits 1:0, then read back
    task automatic set_thr(input logic [7:0] adr, input logic [13:0] v);
        wb(1'b1, adr, {16'h0000, v, 2'($urandom)});
        wb(1'b0, adr, 32'h0000_0000);
        chk("threshold", rd, {16'h0000, v, 2'b00});
        case (adr)
            8'h90: ov_clr = v;
            8'h94: ov_set = v;
            8'h98: uv_clr = v;
            default: uv_set = v;
        endcase
    endtask : set_thr

    // one measurement strobe, then alerts and irq against the model
    task automatic meas(input logic [3:0] c, input logic [13:0] code);
        logic o, u;
        @(posedge clk_i);
        meas_valid_i <= 1'b1;
        meas_cell_i <= c;
        meas_code_i <= code;
        @(posedge clk_i);
        meas_valid_i <= 1'b0;
        if (c < 4'd14)
        begin
            o = ov_m[c];
            u = uv_m[c];
            ov_m[c] = ov_next(o, code);
            uv_m[c] = uv_next(u, code);
            st_m = st_m | {~u & uv_m[c], ~o & ov_m[c]};
        end
        #1;
        chk("ov alerts", 32'(cell_overvoltage_alert_o), 32'(ov_m));
        chk("uv alerts", 32'(cell_undervoltage_alert_o), 32'(uv_m));
        chk("irq", 32'(irq_o), 32'(|(st_m & mask_m)));
    endtask : meas

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        void'($urandom(32'hd18a5004));
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        wb(1'b0, 8'h94, 32'h0000_0000);
        chk("ov set reset", rd, 32'h0000_fffc);
        wb(1'b0, 8'h98, 32'h0000_0000);
        chk("uv clr reset", rd, 32'h0000_0000);
        wb(1'b0, 8'h9c, 32'h0000_0000);
        chk("uv set reset", rd, 32'h0000_0000);
        wb(1'b0, 8'h90, 32'h0000_0000);
        chk("ov clr reset", rd, 32'h0000_fffc);
        // upper lane only: bits 13:6 written, bits 5:0 kept
        sel_v = 4'h2;
        wb(1'b1, 8'h90, 32'h0000_00ff);
        sel_v = 4'hf;
        wb(1'b0, 8'h90, 32'h0000_0000);
        chk("ov clr upper lane", rd, 32'h0000_00fc);
        set_thr(8'h90, 14'h3fff);
        wb(1'b1, 8'h40, 32'hffff_ffff);
        wb(1'b0, 8'h40, 32'h0000_0000);
        chk("unmapped", rd, 32'h0000_0000);
        $display("reset values done");
        // extreme codes with both checks off
        meas(4'd0, 14'h1fff);
        meas(4'd1, 14'h2000);
        wb(1'b1, 8'hc4, 32'h0000_0001);
        mask_m = 2'b01;
        // overvoltage set, hold, clear, then a negative set level
        set_thr(8'h94, 14'h0800);
        set_thr(8'h90, 14'h0400);
        meas(4'd3, 14'h1000);
        meas(4'd3, 14'h0600);
        meas(4'd3, 14'h0400);
        set_thr(8'h94, 14'h3f00);
        meas(4'd4, 14'h0000);
        meas(4'd14, 14'h1fff);
        wb(1'b1, 8'hc0, 32'h0000_0001);
        st_m[0] = 1'b0;
        chk("irq after clear", 32'(irq_o), 32'h0000_0000);
        // undervoltage with the event masked, then unmasked
        set_thr(8'h98, 14'h0400);
        set_thr(8'h9c, 14'h0200);
        meas(4'd5, 14'h3ff0);
        meas(4'd5, 14'h0300);
        wb(1'b0, 8'hc8, 32'h0000_0000);
        chk("alert summary", rd, {30'h0, |uv_m, |ov_m});
        meas(4'd5, 14'h0400);
        wb(1'b0, 8'hc0, 32'h0000_0000);
        chk("status", rd, 32'(st_m));
        wb(1'b1, 8'hc4, 32'h0000_0003);
        mask_m = 2'b11;
        chk("irq unmasked", 32'(irq_o), 32'(|st_m));
        $display("directed alerts done");
        // random levels, ordered so clear sits on the right side
        repeat (300)
        begin
            if ($urandom % 16 == 0)
            begin
                ta = 14'($urandom);
                tb = 14'($urandom);
                if ($signed(ta) > $signed(tb))
                    {ta, tb} = {tb, ta};
                set_thr(($urandom % 2) ? 8'h94 : 8'h9c, ($urandom % 2) ? tb : ta);
                set_thr(8'h90, ($signed(ta) <= $signed(ov_set)) ? ta : ov_set);
                set_thr(8'h98, ($signed(tb) >= $signed(uv_set)) ? tb : uv_set);
            end
            meas(4'($urandom), 14'($urandom));
        end
        wb(1'b1, 8'hc0, 32'h0000_0003);
        st_m = 2'b00;
        chk("irq final", 32'(irq_o), 32'h0000_0000);
        $display("random alerts done");
        report_and_stop();
    end
endmodule : bva_top_tb
